// file: lrg_guard.sv
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - BSY/SEL/RST released when false; others actively negated.
// - Glitch handling on in LVD mode, optional otherwise.
// - Target ignores ACK/ATN from BSY release onward.
// - REQ held negated 2.5 settle delays.
// - C/D, I/O, MSG kept driven while the target drives BSY.
// - Selection data drives only true bits.
// - Bus free one settle delay after BSY, SEL false.
// - Released lines may glitch true for one settle delay.
module lrg_guard #(
   parameter int SETTLE = lrg_pkg::SETTLE_CYC
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // Mode.
   input wire logic lvd_mode,
   input wire logic opt_glitch_en,
   input wire logic role_tgt,
   // Core requests: levels wanted and lines to keep actively driven.
   input wire lrg_pkg::lrg_ctl_s core_drv,
   input wire lrg_pkg::lrg_ctl_s core_en,
   input wire lrg_pkg::lrg_dat_s core_dat,
   input wire logic core_dat_en,
   input wire logic sel_phase,
   // Filtered bus view and status back to the core.
   output lrg_pkg::lrg_ctl_s rx_ctl,
   output lrg_pkg::lrg_dat_s rx_dat,
   output logic bus_free,
   output logic req_hold,
   output logic ack_atn_ignored,
   // Bus pins, true = asserted.
   input wire lrg_pkg::lrg_ctl_s pin_in,
   output lrg_pkg::lrg_ctl_s pin_out,
   output lrg_pkg::lrg_ctl_s pin_oe,
   input wire lrg_pkg::lrg_dat_s dat_in,
   output lrg_pkg::lrg_dat_s dat_out,
   output lrg_pkg::lrg_dat_s dat_oe
);
   import lrg_pkg::*;

   localparam logic [CNT_W-1:0] SETTLE_W = CNT_W'(SETTLE);
   localparam logic [CNT_W-1:0] HOLD_CYC = CNT_W'((5 * SETTLE + 1) / 2);

   lrg_ctl_s ctl_s1_q;
   lrg_ctl_s ctl_s2_q;
   lrg_dat_s dat_s1_q;
   lrg_dat_s dat_s2_q;
   lrg_ctl_s rx_ctl_q;
   lrg_ctl_s rx_ctl_d;
   lrg_dat_s rx_dat_q;
   lrg_ctl_s out_q;
   lrg_ctl_s out_d;
   lrg_ctl_s oe_q;
   lrg_ctl_s oe_d;
   lrg_dat_s dout_q;
   lrg_dat_s dout_d;
   lrg_dat_s doe_q;
   lrg_dat_s doe_d;
   logic bsy_prev_q;
   logic ign_q;
   logic ign_d;
   logic hold_q;
   logic hold_d;
   logic free_q;
   logic hold_done;
   logic free_done;
   logic glitch_en;
   logic bsy_rel;
   logic bsy_take;
   logic free_run;
   logic req_force;
   logic [CNT_W-1:0] hold_age_q;

   // Glitch handling is mandatory with LVD drivers, optional otherwise.
   assign glitch_en = lvd_mode || opt_glitch_en;
   assign bsy_rel = role_tgt && bsy_prev_q && !core_drv.bsy;
   assign bsy_take = core_drv.bsy && !bsy_prev_q;

   // Ignore ACK/ATN from the BSY release until the next connection.
   assign ign_d = (bsy_rel && glitch_en) || (ign_q && !bsy_take);

   // REQ stays actively negated until the hold time has run out.
   assign hold_d = (bsy_rel && glitch_en) || (hold_q && !hold_done);

   // Bus free starts one settle delay after BSY and SEL are both false.
   assign free_run = !ctl_s2_q.bsy && !ctl_s2_q.sel;

   lrg_tmr #(.CYC(HOLD_CYC)) u_hold_tmr (
      .clk(clk),
      .rstn(rstn),
      .run(hold_q),
      .expired(hold_done)
   );

   lrg_tmr #(.CYC(SETTLE_W)) u_free_tmr (
      .clk(clk),
      .rstn(rstn),
      .run(free_run),
      .expired(free_done)
   );

   // Lines that may not be actively negated drive only when true.
   assign out_d.bsy = core_drv.bsy;
   assign oe_d.bsy = core_drv.bsy;
   assign out_d.sel = core_drv.sel;
   assign oe_d.sel = core_drv.sel;
   assign out_d.rst = core_drv.rst;
   assign oe_d.rst = core_drv.rst;
   assign out_d.atn = core_drv.atn;
   assign oe_d.atn = core_en.atn || core_drv.atn;
   assign out_d.ack = core_drv.ack;
   assign oe_d.ack = core_en.ack || core_drv.ack;
   // REQ is forced negated from the very cycle BSY is let go, not one cycle later.
   assign req_force = hold_q || (bsy_rel && glitch_en);
   assign out_d.req = req_force ? 1'b0 : core_drv.req;
   assign oe_d.req = req_force || core_en.req || core_drv.req;
   assign out_d.cd = core_drv.cd;
   assign out_d.io = core_drv.io;
   assign out_d.msg = core_drv.msg;

   // Phase lines are not let go while this target still drives BSY.
   wire tgt_keep = role_tgt && glitch_en && core_drv.bsy;
   assign oe_d.cd = core_en.cd || core_drv.cd || tgt_keep;
   assign oe_d.io = core_en.io || core_drv.io || tgt_keep;
   assign oe_d.msg = core_en.msg || core_drv.msg || tgt_keep;

   // During selection only true data bits are driven.
   assign dout_d = core_dat;
   assign doe_d = sel_phase ? core_dat : (core_dat_en ? 9'h1FF : 9'h000);

   // Ignored lines read as negated, which hides release glitches.
   always_comb begin
      rx_ctl_d = ctl_s2_q;
      rx_ctl_d.ack = ctl_s2_q.ack && !ign_q;
      rx_ctl_d.atn = ctl_s2_q.atn && !ign_q;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctl_s1_q <= '0;
         ctl_s2_q <= '0;
         dat_s1_q <= '0;
         dat_s2_q <= '0;
      end else begin
         ctl_s1_q <= pin_in;
         ctl_s2_q <= ctl_s1_q;
         dat_s1_q <= dat_in;
         dat_s2_q <= dat_s1_q;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bsy_prev_q <= 1'b0;
         ign_q <= 1'b0;
         hold_q <= 1'b0;
         free_q <= 1'b0;
         rx_ctl_q <= '0;
         rx_dat_q <= '0;
      end else begin
         bsy_prev_q <= core_drv.bsy;
         ign_q <= ign_d;
         hold_q <= hold_d;
         free_q <= free_done;
         rx_ctl_q <= rx_ctl_d;
         rx_dat_q <= dat_s2_q;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         out_q <= '0;
         oe_q <= '0;
         dout_q <= '0;
         doe_q <= '0;
      end else begin
         out_q <= out_d;
         oe_q <= oe_d;
         dout_q <= dout_d;
         doe_q <= doe_d;
      end
   end

   // Counts the cycles of one REQ hold, read only by the checks below.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hold_age_q <= CNT_ZERO;
      end else begin
         hold_age_q <= hold_q ? hold_age_q + CNT_ONE : CNT_ZERO;
      end
   end

   assign rx_ctl = rx_ctl_q;
   assign rx_dat = rx_dat_q;
   assign bus_free = free_q;
   assign req_hold = hold_q;
   assign ack_atn_ignored = ign_q;
   assign pin_out = out_q;
   assign pin_oe = oe_q;
   assign dat_out = dout_q;
   assign dat_oe = doe_q;

   property p_wired_or;
      @(posedge clk) disable iff (!rstn)
      (pin_oe.bsy |-> pin_out.bsy) and (pin_oe.sel |-> pin_out.sel)
         and (pin_oe.rst |-> pin_out.rst);
   endproperty
   a_wired_or: assert property (p_wired_or) else $error("BSY/SEL/RST driven negated");

   property p_no_glitch_mode;
      @(posedge clk) disable iff (!rstn)
      (!glitch_en && !hold_q && bsy_rel) |=> !req_hold;
   endproperty
   a_no_glitch_mode: assert property (p_no_glitch_mode) else $error("REQ hold outside mode");

   property p_ignore;
      @(posedge clk) disable iff (!rstn)
      (bsy_rel && glitch_en) |=> ack_atn_ignored ##1 (!rx_ctl.ack && !rx_ctl.atn);
   endproperty
   a_ignore: assert property (p_ignore) else $error("ACK/ATN not ignored after BSY release");

   property p_ignore_keep;
      @(posedge clk) disable iff (!rstn)
      (ign_q && !core_drv.bsy) |=> ign_q;
   endproperty
   a_ignore_keep: assert property (p_ignore_keep) else $error("ACK/ATN ignore ended early");

   property p_req_neg;
      @(posedge clk) disable iff (!rstn)
      (req_hold || (bsy_rel && glitch_en)) |=> (pin_oe.req && !pin_out.req);
   endproperty
   a_req_neg: assert property (p_req_neg) else $error("REQ not actively negated in hold");

   property p_hold_len;
      @(posedge clk) disable iff (!rstn)
      $fell(req_hold) |-> (hold_age_q == HOLD_CYC);
   endproperty
   a_hold_len: assert property (p_hold_len) else $error("REQ hold length wrong");

   property p_phase_keep;
      @(posedge clk) disable iff (!rstn)
      (role_tgt && glitch_en && core_drv.bsy) |=> (pin_oe.cd && pin_oe.io && pin_oe.msg);
   endproperty
   a_phase_keep: assert property (p_phase_keep) else $error("Phase line released under BSY");

   property p_sel_data;
      @(posedge clk) disable iff (!rstn)
      sel_phase |=> (dat_oe == $past(core_dat)) && ((dat_out & ~dat_oe) == 9'h000);
   endproperty
   a_sel_data: assert property (p_sel_data) else $error("False data bit driven in selection");

   property p_bus_free;
      @(posedge clk) disable iff (!rstn)
      $rose(bus_free) |-> ($past(free_run, 1) && $past(free_run, SETTLE));
   endproperty
   a_bus_free: assert property (p_bus_free) else $error("Bus free declared too early");

endmodule : lrg_guard

`default_nettype wire

// file: lrg_pkg.sv
package lrg_pkg;

   // Control lines of the parallel bus, one bit per line, true = asserted.
   typedef struct packed {
      logic bsy;
      logic sel;
      logic rst;
      logic atn;
      logic ack;
      logic req;
      logic cd;
      logic io;
      logic msg;
   } lrg_ctl_s;

   // Eight data bits and their parity bit.
   typedef struct packed {
      logic par;
      logic [7:0] dat;
   } lrg_dat_s;

   localparam int CNT_W = 16;
   localparam int CLK_PERIOD_NS = 100;
   // Bus settle delay used when no other figure is configured.
   localparam int SETTLE_NS = 400;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

endpackage : lrg_pkg

// file: lrg_tmr.sv
`timescale 1ns/1ns
`default_nettype none

// Counts cycles while run is high and flags from the CYC-th cycle of run onward.
module lrg_tmr #(
   parameter logic [15:0] CYC = 16'h0004
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // Control and result.
   input wire logic run,
   output logic expired
);
   import lrg_pkg::*;

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;

   assign expired = run && (cnt_q == CNT_ZERO);
   assign cnt_d = !run ? (CYC - CNT_ONE) : (expired ? cnt_q : cnt_q - CNT_ONE);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         // Start loaded, so a line that is idle from reset still waits the full count.
         cnt_q <= CYC - CNT_ONE;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule : lrg_tmr

`default_nettype wire

// file: lrg_peer.sv
`timescale 1ns/1ns
`default_nettype none

// Far-side initiator and the terminated wire: a line reads true only while driven true.
module lrg_peer (
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // Request from the bench to assert ACK.
   input wire logic ack_req,
   // Device pin drivers.
   input wire lrg_pkg::lrg_ctl_s dev_out,
   input wire lrg_pkg::lrg_ctl_s dev_oe,
   input wire lrg_pkg::lrg_dat_s ddev_out,
   input wire lrg_pkg::lrg_dat_s ddev_oe,
   // Resolved wire levels.
   output lrg_pkg::lrg_ctl_s bus,
   output lrg_pkg::lrg_dat_s dbus,
   // Initiator's view of REQ.
   output logic req_view
);
   import lrg_pkg::*;
   lrg_ctl_s peer_q;
   logic bsy_q;
   logic req_ign_q;
   // ACK and ATN stay actively negated unless the bench asks for ACK.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         peer_q <= lrg_ctl_s'(9'h000);
      end else begin
         peer_q <= lrg_ctl_s'({4'h0, ack_req, 4'h0});
      end
   end
   // Released lines fall to negated through the terminators.
   assign bus = lrg_ctl_s'((dev_out & dev_oe) | peer_q);
   assign dbus = lrg_dat_s'(ddev_out & ddev_oe);
   // The initiator stops looking at REQ one cycle after it sees BSY fall.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bsy_q <= 1'b0;
         req_ign_q <= 1'b0;
      end else begin
         bsy_q <= bus.bsy;
         req_ign_q <= !bus.bsy && (bsy_q || req_ign_q);
      end
   end
   assign req_view = bus.req && !req_ign_q;
endmodule : lrg_peer

`default_nettype wire

// file: lrg_guard_tb.sv
`timescale 1ns/1ns
`default_nettype none

module lrg_guard_tb;
   import lrg_pkg::*;
   localparam int ST = 2;
   localparam int HOLD = (5 * ST + 1) / 2;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic lvd = 1'b1, opt = 1'b0, tgt = 1'b1, den = 1'b0, selp = 1'b0, ackr = 1'b0;
   lrg_ctl_s drv = '0, en = '0, rx, po, poe, pin;
   lrg_dat_s cdat = '0, rxd, dout, doe, din;
   logic free, hold, ign, rv;
   int num_errors = 0, checked = 0, n;

   always #50 clk = ~clk;

   lrg_guard #(.SETTLE(ST)) u_dut (.clk(clk), .rstn(rstn), .lvd_mode(lvd),
      .opt_glitch_en(opt), .role_tgt(tgt), .core_drv(drv), .core_en(en), .core_dat(cdat),
      .core_dat_en(den), .sel_phase(selp), .rx_ctl(rx), .rx_dat(rxd), .bus_free(free),
      .req_hold(hold), .ack_atn_ignored(ign), .pin_in(pin), .pin_out(po), .pin_oe(poe),
      .dat_in(din), .dat_out(dout), .dat_oe(doe));
   lrg_peer u_peer (.clk(clk), .rstn(rstn), .ack_req(ackr), .dev_out(po), .dev_oe(poe),
      .ddev_out(dout), .ddev_oe(doe), .bus(pin), .dbus(din), .req_view(rv));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask : cyc

   task automatic give_verdict;
      $display("checked=%0d num_errors=%0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict

   // A wait that used up its bound ends the run as a failure.
   task automatic cap(input int k, input int lim);
      if (k >= lim) begin
         num_errors++;
         give_verdict;
      end
   endtask : cap

   task automatic t_drive;
      @(posedge clk);
      en <= lrg_ctl_s'(9'h1FF);
      drv <= '0;
      selp <= 1'b1;
      cdat <= lrg_dat_s'(9'h0A5);
      cyc(3);
      chk({13'h0, poe.bsy, poe.sel, poe.rst}, 16'h0000);
      chk({7'h0, doe}, 16'h00A5);
      @(posedge clk);
      selp <= 1'b0;
      den <= 1'b1;
      cyc(3);
      chk({7'h0, doe}, 16'h01FF);
      chk({7'h0, rxd}, 16'h00A5);
      chk({12'h0, poe.ack, poe.atn, poe.req, poe.cd}, 16'h000F);
      @(posedge clk);
      den <= 1'b0;
      en <= '0;
      $display("test drive done");
   endtask : t_drive

   task automatic t_release(input logic on, input logic op, input logic [15:0] exp);
      logic g;
      g = on | op;
      @(posedge clk);
      lvd <= on;
      opt <= op;
      drv <= lrg_ctl_s'(9'h100);
      en <= '0;
      ackr <= 1'b1;
      cyc(5);
      chk({15'h0, poe.cd}, {15'h0, g});
      chk({15'h0, rx.ack}, 16'h0001);
      @(posedge clk);
      drv.bsy <= 1'b0;
      n = 0;
      cyc(2);
      chk({15'h0, poe.req}, {15'h0, g});
      cyc(1);
      chk({13'h0, ign, rx.ack, po.req}, {13'h0, g, !g, 1'b0});
      chk({15'h0, rv}, 16'h0000);
      while (hold === 1'b1 && n < 40) begin
         n++;
         cyc(1);
      end
      cap(n, 40);
      chk(n[15:0], exp);
      cyc(4);
      chk({14'h0, ign, poe.req}, {14'h0, g, 1'b0});
      @(posedge clk);
      ackr <= 1'b0;
      drv <= '0;
      en <= '0;
      lvd <= 1'b1;
      opt <= 1'b0;
      $display("test release done");
   endtask : t_release

   task automatic t_free;
      @(posedge clk);
      tgt <= 1'b0;
      drv.bsy <= 1'b1;
      en.bsy <= 1'b1;
      cyc(ST + 6);
      chk({15'h0, free}, 16'h0000);
      chk({15'h0, poe.cd}, 16'h0000);
      @(posedge clk);
      drv.bsy <= 1'b0;
      cyc(1);
      n = 0;
      while (pin.bsy !== 1'b0 && n < 20) begin
         n++;
         cyc(1);
      end
      cap(n, 20);
      n = 0;
      while (free !== 1'b1 && n < 40) begin
         n++;
         cyc(1);
      end
      cap(n, 40);
      chk(n[15:0], 16'(2 + ST));
      chk({14'h0, hold, ign}, 16'h0000);
      $display("test bus free done");
   endtask : t_free

   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      cyc(1);
      chk({rx, free, hold, ign, 4'h0}, 16'h0000);
      t_drive;
      t_release(1'b1, 1'b0, 16'(HOLD - 1));
      t_release(1'b0, 1'b0, 16'h0000);
      t_release(1'b0, 1'b1, 16'(HOLD - 1));
      t_free;
      give_verdict;
   end

   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      give_verdict;
   end
endmodule : lrg_guard_tb

`default_nettype wire
